// File: verilog/emb_port.sv
// External memory bus port: master-side address, data, strobes and attributes
// Behaviour
// RL1 - Stop or wait releases bus, floats all pins; the code still drives bus_busy_line_n high
// RL2 - Drive 18 address lines while bus master
// RL3 - Float address lines when not bus master
// RL4 - Address holds last value when idle
// RL5 - 24 data lines bidirectional while bus master
// RL6 - Float data lines when not bus master
// RL7 - Stop/wait: data inputs ignored, outputs floated
// RL8 - Active-low read strobe, floated when not master
// RL9 - Active-low write strobe, floated when not master
// RL10 - One attribute line unless priority disabled
// RL11 - Drive data only on writes; sample reads
`timescale 1ns/1ps
`default_nettype none
module emb_port #(
  parameter int ADDR_W = emb_pkg::ADDR_W,
  parameter int DATA_W = emb_pkg::DATA_W,
  parameter int ATTR_W = emb_pkg::ATTR_W
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_bus_grant,
  input  wire logic                 i_low_power,
  input  wire logic                 i_attribute_priority_disable,
  input  wire logic                 i_req_valid,
  input  wire emb_pkg::emb_req_t    i_req,
  input  wire logic [DATA_W-1:0]    i_data_pin,
  output logic                      o_req_ready,
  output logic                      o_rdata_valid,
  output logic [DATA_W-1:0]         o_rdata,
  output logic                      o_bus_master,
  output emb_pkg::emb_pins_t        o_pins
);
  logic                rst_sync_ff;
  logic                rst_n_ff;
  logic [DATA_W-1:0]   din_meta_ff;
  logic [DATA_W-1:0]   din_ff;
  emb_pkg::emb_state_t state_ff;
  emb_pkg::emb_state_t nxt_state;
  logic                master_ff;
  logic [ADDR_W-1:0]   addr_ff;
  logic [DATA_W-1:0]   wdata_ff;
  logic [ATTR_W-1:0]   attr_ff;
  logic                rd_n_ff;
  logic                wr_n_ff;
  logic                data_oe_ff;
  logic                rvalid_ff;
  logic [DATA_W-1:0]   rdata_ff;
  logic [ATTR_W-1:0]   attr_sel;
  logic [1:0]          rd_cnt_ff;
  logic                ready_ff;
  logic                busy_n_ff;

  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_sync_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end
    else
    begin
      rst_sync_ff <= 1'b1;
      rst_n_ff    <= rst_sync_ff;
    end
  end

  // Data pins come from outside; two flops before use
  always_ff @(posedge i_clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      din_meta_ff <= emb_pkg::DATA_RST;
      din_ff      <= emb_pkg::DATA_RST;
    end
    else
    begin
      din_meta_ff <= i_data_pin;
      din_ff      <= din_meta_ff;
    end
  end

  emb_attr_prio #(
    .W (ATTR_W)
  ) u_attr_prio (
    .i_attr     (i_req.attr),
    .i_prio_dis (i_attribute_priority_disable),
    .o_attr     (attr_sel)
  );

  wire master_nxt = i_bus_grant & ~i_low_power; // RL1
  wire accept     = master_ff & master_nxt & i_req_valid & (state_ff == emb_pkg::EMB_IDLE);
  wire rd_last    = (rd_cnt_ff == 2'(emb_pkg::RD_CYCLES - 1));

  // Read stays until the synchronised data reflects the driven address
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      emb_pkg::EMB_IDLE:
        if (accept)
          nxt_state = i_req.write ? emb_pkg::EMB_WRITE : emb_pkg::EMB_READ;
      emb_pkg::EMB_READ:  nxt_state = rd_last ? emb_pkg::EMB_IDLE : emb_pkg::EMB_READ;
      emb_pkg::EMB_WRITE: nxt_state = emb_pkg::EMB_IDLE;
      default:            nxt_state = emb_pkg::EMB_IDLE;
    endcase
    if (!master_nxt)
      nxt_state = emb_pkg::EMB_IDLE; // RL1
  end

  always_ff @(posedge i_clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      state_ff   <= emb_pkg::EMB_IDLE;
      master_ff  <= 1'b0;
      ready_ff   <= 1'b0;
      busy_n_ff  <= 1'b1;
      rd_cnt_ff  <= 2'h0;
      rd_n_ff    <= 1'b1;
      wr_n_ff    <= 1'b1;
      data_oe_ff <= 1'b0;
    end
    else
    begin
      state_ff   <= nxt_state;
      master_ff  <= master_nxt; // RL1
      ready_ff   <= master_nxt & (nxt_state == emb_pkg::EMB_IDLE);
      busy_n_ff  <= ~master_nxt;
      rd_cnt_ff  <= (state_ff == emb_pkg::EMB_READ) ? rd_cnt_ff + 2'h1 : 2'h0;
      rd_n_ff    <= (nxt_state != emb_pkg::EMB_READ); // RL8
      wr_n_ff    <= (nxt_state != emb_pkg::EMB_WRITE); // RL9
      data_oe_ff <= (nxt_state == emb_pkg::EMB_WRITE); // RL11
    end
  end

  // Address held between accesses to avoid toggling
  always_ff @(posedge i_clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      addr_ff  <= emb_pkg::ADDR_RST;
      wdata_ff <= emb_pkg::DATA_RST;
      attr_ff  <= emb_pkg::ATTR_RST;
    end
    else if (accept)
    begin
      addr_ff  <= i_req.addr; // RL4
      wdata_ff <= i_req.wdata;
      attr_ff  <= attr_sel; // RL10
    end
  end

  // Read data sampled at end of read; inputs ignored otherwise
  always_ff @(posedge i_clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= emb_pkg::DATA_RST;
    end
    else
    begin
      rvalid_ff <= (state_ff == emb_pkg::EMB_READ) & rd_last & master_nxt; // RL7
      if ((state_ff == emb_pkg::EMB_READ) && rd_last && master_nxt)
        rdata_ff <= din_ff; // RL11
    end
  end

  assign o_req_ready   = ready_ff;
  assign o_rdata_valid = rvalid_ff;
  assign o_rdata       = rdata_ff;
  assign o_bus_master  = master_ff;

  assign o_pins.addr            = addr_ff;
  assign o_pins.addr_oe         = master_ff; // RL2 RL3
  assign o_pins.data            = wdata_ff;
  assign o_pins.data_oe         = data_oe_ff; // RL5 RL6 RL7
  assign o_pins.attr            = attr_ff;
  assign o_pins.attr_oe         = master_ff;
  assign o_pins.rd_n            = rd_n_ff;
  assign o_pins.wr_n            = wr_n_ff;
  assign o_pins.bus_busy_line_n = busy_n_ff;
  assign o_pins.strobe_oe       = master_ff; // RL8 RL9

  property p_lp_float;
    @(posedge i_clk) disable iff (!rst_n_ff)
    i_low_power |=> !o_pins.addr_oe && !o_pins.data_oe && !o_pins.strobe_oe;
  endproperty
  a_lp_float: assert property (p_lp_float) else $error("pins driven in low power"); // RL1

  property p_addr_oe;
    @(posedge i_clk) disable iff (!rst_n_ff)
    (rst_n_ff && i_bus_grant && !i_low_power) |=> o_pins.addr_oe;
  endproperty
  a_addr_oe: assert property (p_addr_oe) else $error("address not driven as master"); // RL2

  property p_addr_float;
    @(posedge i_clk) disable iff (!rst_n_ff)
    !o_bus_master |-> !o_pins.addr_oe && !o_pins.attr_oe;
  endproperty
  a_addr_float: assert property (p_addr_float) else $error("address driven off bus"); // RL3

  property p_addr_hold;
    @(posedge i_clk) disable iff (!rst_n_ff)
    !(o_req_ready && i_req_valid) |=> $stable(o_pins.addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address changed while idle"); // RL4

  property p_write_drive;
    @(posedge i_clk) disable iff (!rst_n_ff)
    (o_req_ready && i_req_valid && i_req.write && master_nxt)
      |=> o_pins.data_oe && !o_pins.wr_n && o_pins.data == $past(i_req.wdata);
  endproperty
  a_write_drive: assert property (p_write_drive) else $error("write data not driven"); // RL5

  property p_data_float;
    @(posedge i_clk) disable iff (!rst_n_ff)
    !o_bus_master |-> !o_pins.data_oe;
  endproperty
  a_data_float: assert property (p_data_float) else $error("data driven off bus"); // RL6

  property p_lp_ignore;
    @(posedge i_clk) disable iff (!rst_n_ff)
    i_low_power |=> !o_rdata_valid;
  endproperty
  a_lp_ignore: assert property (p_lp_ignore) else $error("data taken in low power"); // RL7

  property p_read;
    @(posedge i_clk) disable iff (!rst_n_ff)
    (o_req_ready && i_req_valid && !i_req.write && master_nxt && !i_low_power)
      |=> !o_pins.rd_n && o_pins.wr_n && !o_pins.data_oe;
  endproperty
  a_read: assert property (p_read) else $error("read strobe wrong"); // RL8 RL11

  property p_read_end;
    @(posedge i_clk) disable iff (!rst_n_ff)
    (o_req_ready && i_req_valid && !i_req.write && master_nxt) ##1 master_nxt[*3]
      |-> !o_pins.rd_n ##1 o_pins.rd_n && o_rdata_valid;
  endproperty
  a_read_end: assert property (p_read_end) else $error("read did not complete"); // RL8 RL11

  property p_strobe_excl;
    @(posedge i_clk) disable iff (!rst_n_ff)
    !(!o_pins.rd_n && !o_pins.wr_n);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl) else $error("read and write together"); // RL9

  property p_attr_one;
    @(posedge i_clk) disable iff (!rst_n_ff)
    (o_req_ready && i_req_valid && master_nxt && !i_attribute_priority_disable)
      |=> $onehot0(o_pins.attr);
  endproperty
  a_attr_one: assert property (p_attr_one) else $error("several attribute lines"); // RL10
endmodule
`default_nettype wire

// File: shared/emb_pkg.sv
// Package for the external memory bus port: widths, reset values, request and pin structs
package emb_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 24;
  localparam int ATTR_W = 4;
  // Default operating-mode bit that lifts the one-hot attribute limit
  localparam int ATTR_PRIO_DIS_BIT = 14;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 24'h000000;
  localparam logic [ATTR_W-1:0] ATTR_RST = 4'h0;
  // Read strobe length: two cycles for the data synchroniser, one for the pins to settle
  localparam int RD_CYCLES = 3;

  typedef enum logic [1:0] {
    EMB_IDLE  = 2'b00,
    EMB_READ  = 2'b01,
    EMB_WRITE = 2'b10
  } emb_state_t;

  // One access request from the core
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [ATTR_W-1:0] attr;
  } emb_req_t;

  // Output pins with their enables
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              addr_oe;
    logic [DATA_W-1:0] data;
    logic              data_oe;
    logic [ATTR_W-1:0] attr;
    logic              attr_oe;
    logic              rd_n;
    logic              wr_n;
    logic              bus_busy_line_n;
    logic              strobe_oe;
  } emb_pins_t;
endpackage

// File: verilog/emb_attr_prio.sv
// Address attribute priority: keeps only the lowest asserted line unless disabled
`timescale 1ns/1ps
`default_nettype none
module emb_attr_prio #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] i_attr,
  input  wire logic         i_prio_dis,
  output logic      [W-1:0] o_attr
);
  wire [W-1:0] lowest = i_attr & (~i_attr + W'(1));
  assign o_attr = i_prio_dis ? i_attr : lowest; // RL10
endmodule
`default_nettype wire

// File: dv/emb_mem_model.sv
// Behavioural external memory facing the port pins
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model (
  input  wire logic               i_clk,
  input  wire emb_pkg::emb_pins_t i_pins,
  output logic [23:0]             o_level
);
  logic [23:0] mem [16];
  logic [23:0] last_ff = 24'h5A5A5A;
  logic [1:0]  hold_ff = 2'h0;
  wire logic   rd_on = i_pins.strobe_oe & ~i_pins.rd_n;
  // Released bus shows a changing pattern, so stale data never matches
  always_comb
    if (i_pins.data_oe)
      o_level = i_pins.data;
    else if (rd_on || hold_ff != 2'h0)
      o_level = mem[i_pins.addr[3:0]];
    else
      o_level = ~last_ff;
  always_ff @(posedge i_clk)
  begin
    last_ff <= o_level;
    hold_ff <= rd_on ? 2'h2 : hold_ff - {1'b0, hold_ff != 2'h0};
    if (i_pins.data_oe & ~i_pins.wr_n)
      mem[i_pins.addr[3:0]] <= i_pins.data;
  end
endmodule
`default_nettype wire

// File: dv/external_memory_bus_port_bench.sv
// Self-checking bench for the external memory bus port
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_port_bench;
  typedef struct packed {
    logic w; logic [17:0] a; logic [23:0] d; logic [3:0] at; logic pd; logic [3:0] ea;
  } emb_row_t;
  logic               clk, rst_n, grant, lp, pd, valid, ready, rv, master;
  logic [23:0]        dpin, rdata;
  emb_pkg::emb_req_t  req;
  emb_pkg::emb_pins_t pins;
  int                 err_total, check_count, cyc;
  emb_row_t rows [6] = '{
    '{1'b1, 18'h3FFF1, 24'hA5A5A5, 4'hC, 1'b0, 4'h4},
    '{1'b0, 18'h3FFF1, 24'hA5A5A5, 4'hC, 1'b1, 4'hC},
    '{1'b1, 18'h00002, 24'hFFFFFF, 4'hF, 1'b0, 4'h1},
    '{1'b0, 18'h00002, 24'hFFFFFF, 4'h0, 1'b0, 4'h0},
    '{1'b1, 18'h20003, 24'h000000, 4'h8, 1'b0, 4'h8},
    '{1'b0, 18'h20003, 24'h000000, 4'hA, 1'b1, 4'hA}};
  emb_port i_dut (.i_clk(clk), .i_reset_n(rst_n), .i_bus_grant(grant), .i_low_power(lp),
    .i_attribute_priority_disable(pd), .i_req_valid(valid), .i_req(req), .i_data_pin(dpin),
    .o_req_ready(ready), .o_rdata_valid(rv), .o_rdata(rdata), .o_bus_master(master),
    .o_pins(pins));
  emb_mem_model i_mem (.i_clk(clk), .i_pins(pins), .o_level(dpin));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic go(input logic w, input logic [17:0] a, input logic [23:0] d,
                    input logic [3:0] at);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 20)
    begin
      @(posedge clk) #1;
      n++;
    end
    chk(ready, 1'b1);
    req = '{w, a, d, at};
    valid = 1'b1;
    @(posedge clk) #1;
    valid = 1'b0;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      err_total++;
      end_sim();
    end
  end
  initial
  begin
    grant = 1'b1; lp = 1'b0; pd = 1'b0; valid = 1'b0; req = '0; rst_n = 1'b0;
    repeat (20) @(posedge clk);
    #1 chk({pins.addr_oe, pins.data_oe, pins.strobe_oe, pins.rd_n, pins.wr_n}, 5'h03);
    $display("reset check done");
    rst_n = 1'b1;
    foreach (rows[i])
    begin
      pd = rows[i].pd;
      go(rows[i].w, rows[i].a, rows[i].d, rows[i].at);
      if (rows[i].w)
        chk({pins.wr_n, pins.rd_n, pins.data_oe, pins.data}, {3'b011, rows[i].d});
      else
        chk({pins.rd_n, pins.wr_n, pins.data_oe, pins.strobe_oe}, 4'h5);
      chk({pins.addr_oe, pins.addr, pins.attr}, {1'b1, rows[i].a, rows[i].ea});
      @(posedge clk) #1;
      if (!rows[i].w)
      begin
        chk({pins.rd_n, ready, rv}, 3'b000);
        repeat (2) @(posedge clk) #1;
        chk({rv, rdata}, {1'b1, rows[i].d});
      end
      chk({pins.wr_n, pins.rd_n, pins.data_oe}, 3'b110);
      $display("row %0d done", i);
    end
    repeat (3) @(posedge clk) #1;
    chk({pins.addr_oe, pins.addr}, {1'b1, 18'h20003});
    go(1'b0, 18'h3FFF1, 24'h000000, 4'h1);
    lp = 1'b1;
    @(posedge clk) #1;
    chk({rv, master, pins.addr_oe, pins.data_oe, pins.attr_oe, pins.strobe_oe, ready}, 0);
    $display("low power abort done");
    lp = 1'b0;
    repeat (2) @(posedge clk) #1;
    chk({rv, master, rdata}, {2'b01, 24'h000000});
    grant = 1'b0;
    @(posedge clk) #1;
    chk({master, pins.addr_oe, pins.data_oe, pins.strobe_oe}, 4'h0);
    $display("grant loss done");
    grant = 1'b1;
    go(1'b1, 18'h00005, 24'h123456, 4'h2);
    rst_n = 1'b0;
    #1 chk({pins.data_oe, pins.strobe_oe, pins.addr_oe, pins.wr_n}, 4'h1);
    @(posedge clk) #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk) #1;
    chk({ready, master, pins.bus_busy_line_n}, 3'b001);
    @(posedge clk) #1;
    chk({ready, master, pins.bus_busy_line_n}, 3'b110);
    chk({rv, rdata}, 25'h0000000);
    $display("mid-run reset done");
    end_sim();
  end
endmodule
`default_nettype wire
